// ===== common/act_consts.svh
`ifndef ACT_CONSTS_SVH
`define ACT_CONSTS_SVH

// Table geometry
`define ACT_ENTRIES 16
`define ACT_IDX_W 4
`define ACT_KEY_W 222
`define ACT_TCAM_W 445
`define ACT_TCAM_WORDS 16
`define ACT_ANS_W 98
`define ACT_ANS_WORDS 4
`define ACT_ADDR_W 19
`define ACT_DATA_W 32

// Word addresses on the configuration port
`define ACT_TCAM_BASE 19'h41BAB
`define ACT_TCAM_SPAN 19'h00100
`define ACT_ANS_BASE 19'h1A3D7
`define ACT_ANS_SPAN 19'h00040
`define ACT_CTRL_ADDR 19'h41093
`define ACT_TPID_ADDR 19'h41094
`define ACT_DROPS_ADDR 19'h41095
`define ACT_STATUS_ADDR 19'h41096

// Ternary entry layout
`define ACT_T_VALID 0
`define ACT_T_MASK 222:1
`define ACT_T_DATA 444:223

// Answer word layout
`define ACT_A_MAC_EN 0
`define ACT_A_MAC_IDX 9:1
`define ACT_A_MAC_PRIO 10
`define ACT_A_TO_HOST 11
`define ACT_A_HOP_DEC 12
`define ACT_A_DISCARD 13
`define ACT_A_REDIR_EN 14
`define ACT_A_REDIR_TGT 20:15
`define ACT_A_COPY_EN 21
`define ACT_A_COPY_TGT 27:22
`define ACT_A_COPY_PRIO 28
`define ACT_A_NO_LEARN 29
`define ACT_A_STAT_EN 30
`define ACT_A_STAT_IDX 38:31
`define ACT_A_DEI_EN 39
`define ACT_A_DEI_NEW 40
`define ACT_A_PCP_EN 41
`define ACT_A_PCP_NEW 44:42
`define ACT_A_VID_EN 45
`define ACT_A_VID_NEW 57:46
`define ACT_A_TPID_EN 58
`define ACT_A_TPID_SEL 60:59
`define ACT_A_DEI_PRIO 61
`define ACT_A_PCP_PRIO 62
`define ACT_A_VID_PRIO 63
`define ACT_A_TPID_PRIO 64
`define ACT_A_COL_EN 65
`define ACT_A_COL 67:66
`define ACT_A_COL_PRIO 68
`define ACT_A_POL_VALID 69
`define ACT_A_POL_PTR 76:70
`define ACT_A_POL_ORDER 78:77
`define ACT_A_QUEUE_EN 79
`define ACT_A_QUEUE 82:80
`define ACT_A_QUEUE_PRIO 83
`define ACT_A_IVID_EN 84
`define ACT_A_IVID 96:85
`define ACT_A_IVID_PRIO 97

// Control register bits and reset values
`define ACT_CTRL_SEL 0
`define ACT_CTRL_TTL_HOST 1
`define ACT_TPID_CUSTOMER 16'h8100
`define ACT_TPID_SERVICE 16'h88A8
`define ACT_TPID_USER_RST 16'h8100
`define ACT_DROPS_W 32

`endif

// ===== common/act_pkg.sv
`include "act_consts.svh"

package act_pkg;

  typedef logic [`ACT_TCAM_W-1:0] act_tentry_t;
  typedef logic [`ACT_ANS_W-1:0] act_answer_t;

  typedef enum logic [1:0] {
    ACT_TPID_C,
    ACT_TPID_S,
    ACT_TPID_USER,
    ACT_TPID_RSVD
  } act_tpid_sel_t;

  typedef struct packed {
    act_tentry_t [`ACT_ENTRIES-1:0] tcam;
    act_answer_t [`ACT_ENTRIES-1:0] ans;
    logic [`ACT_DATA_W-1:0] rdata;
    logic sel_hash;
    logic ttl_to_host;
    logic [15:0] user_tpid;
    logic [`ACT_DROPS_W-1:0] drops;
    logic res_valid;
    logic res_hit;
    logic res_from_hash;
    logic [`ACT_IDX_W-1:0] res_index;
    act_answer_t res_ans;
    logic [7:0] res_ttl;
    logic res_discard;
    logic res_to_host;
    logic res_tpid_update;
    logic [15:0] res_tpid;
    logic res_stat_update;
  } act_state_t;

endpackage : act_pkg

// ===== rtl/act_tcam_lookup.sv
// Function
// [R1] Sixteen ternary entries of sixteen words each, all matched against the key at once.
// [R2] Entry bit 0 is valid; an invalid entry never hits.
// [R3] Entry bits 222:1 are the compare mask, reset to all ones.
// [R4] Mask bit 1 compares that key bit, mask bit 0 ignores it.
// [R5] Software stores pattern pre-masked; hardware masks only the key.
// [R6] Sixteen answers of four words; hit index selects the answer word.
// [R7] Bit 0 MAC rewrite, bits 9:1 action index, bit 10 its priority.
// [R8] Bit 11 forwards the packet to the host port.
// [R9] Bit 12 decrements hop limit, saturating; zero drops or goes to host.
// [R10] Bit 13 discards the packet and counts it in the engine drop counter.
// [R11] Bit 14 redirects to the port in bits 20:15.
// [R12] Bit 21 copies the packet to port 27:22; bit 28 its priority.
// [R13] Bit 29 suppresses source address learning.
// [R14] Bit 30 updates the statistics counter chosen by bits 38:31.
// [R15] Bit 39 rewrites DEI with bit 40; bit 61 its priority.
// [R16] Bit 41 rewrites PCP with bits 44:42; bit 62 its priority.
// [R17] Bit 45 rewrites VLAN id with bits 57:46; bit 63 its priority.
// [R18] Bit 58 changes tag type by code 60:59; bit 64 its priority.
// [R19] Bit 65 forces colour 67:66; bit 68 its priority.
// [R20] Bit 69 validates policer pointer 76:70, order in 78:77.
// [R21] Bit 79 forces egress queue 82:80; bit 83 its priority.
// [R22] Bit 84 overrides ingress VLAN id 96:85; bit 97 its priority.
// [R23] With both answers present, select 0 takes ternary, 1 takes hash.
// [R24] Lowest-numbered matching entry wins; no match reports no hit.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "act_consts.svh"

module act_tcam_lookup
  import act_pkg::*;
(
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  // Configuration port
  input wire logic [`ACT_ADDR_W-1:0] CFG_ADDR,
  input wire logic [`ACT_DATA_W-1:0] CFG_WDATA,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  output logic [`ACT_DATA_W-1:0] CFG_RDATA,
  // Lookup request
  input wire logic LOOKUP_VALID,
  input wire logic [`ACT_KEY_W-1:0] LOOKUP_KEY,
  input wire logic [7:0] LOOKUP_TTL,
  input wire logic HASH_HIT,
  input wire logic [`ACT_ANS_W-1:0] HASH_ANSWER,
  // Lookup result
  output logic RES_VALID,
  output logic RES_HIT,
  output logic RES_FROM_HASH,
  output logic [`ACT_IDX_W-1:0] RES_INDEX,
  output logic [`ACT_ANS_W-1:0] RES_ANSWER,
  // Decoded actions
  output logic MAC_REWRITE_EN,
  output logic [8:0] MAC_ACTION_INDEX,
  output logic MAC_REWRITE_PRIORITY,
  output logic TO_HOST_PORT,
  output logic HOP_LIMIT_DECREMENT,
  output logic [7:0] RES_TTL,
  output logic DISCARD_EN,
  output logic REDIRECT_EN,
  output logic [5:0] REDIRECT_TARGET,
  output logic INGRESS_COPY_EN,
  output logic [5:0] COPY_TARGET_PORT,
  output logic COPY_PRIORITY,
  output logic SUPPRESS_SRC_LEARN,
  output logic STAT_UPDATE_EN,
  output logic [7:0] STAT_INDEX,
  output logic DROP_ELIGIBLE_UPDATE_EN,
  output logic DROP_ELIGIBLE_NEW,
  output logic DROP_ELIGIBLE_PRIORITY,
  output logic PRIO_CODE_UPDATE_EN,
  output logic [2:0] PRIO_CODE_NEW,
  output logic PRIO_CODE_PRIORITY,
  output logic VLAN_ID_UPDATE_EN,
  output logic [11:0] VLAN_ID_NEW,
  output logic VLAN_ID_PRIORITY,
  output logic TAG_TYPE_UPDATE_EN,
  output logic [15:0] TAG_TYPE_VALUE,
  output logic TAG_TYPE_PRIORITY,
  output logic COLOUR_FORCE_EN,
  output logic [1:0] COLOUR_VALUE,
  output logic COLOUR_PRIORITY,
  output logic POLICER_PTR_VALID,
  output logic [6:0] POLICER_PTR,
  output logic [1:0] POLICER_PTR_ORDER,
  output logic QUEUE_FORCE_EN,
  output logic [2:0] EGRESS_QUEUE_VALUE,
  output logic QUEUE_PRIORITY,
  output logic INGRESS_VLAN_OVERRIDE_EN,
  output logic [11:0] INGRESS_VLAN_OVERRIDE,
  output logic INGRESS_VLAN_OVERRIDE_PRIORITY
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  act_state_t s_r;
  act_state_t s_nxt;

  function automatic act_state_t reset_state();
    act_state_t r;
    r = '0;
    for (int i = 0; i < `ACT_ENTRIES; i++) begin
      r.tcam[i][`ACT_T_MASK] = '1; // [R3]
    end
    r.user_tpid = `ACT_TPID_USER_RST;
    return r;
  endfunction : reset_state

  ////////////////////////////////////////////////////////////////////////////
  // Parallel ternary match

  logic [`ACT_ENTRIES-1:0] entry_hit;

  always_comb begin
    for (int i = 0; i < `ACT_ENTRIES; i++) begin
      // Pattern is trusted to be pre-masked, saving a second AND per bit
      entry_hit[i] = s_r.tcam[i][`ACT_T_VALID] && // [R1] [R2]
                     ((LOOKUP_KEY & s_r.tcam[i][`ACT_T_MASK]) == s_r.tcam[i][`ACT_T_DATA]); // [R4] [R5]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [`ACT_ADDR_W-1:0] t_ofs;
  logic [`ACT_ADDR_W-1:0] a_ofs;
  logic t_sel;
  logic a_sel;
  logic tcam_hit;
  logic [`ACT_IDX_W-1:0] hit_idx;
  act_answer_t sel_ans;
  logic use_hash;
  logic any_hit;
  logic [7:0] ttl_dec;
  logic ttl_expired;
  logic [`ACT_TCAM_WORDS*`ACT_DATA_W-1:0] t_word;
  logic [`ACT_ANS_WORDS*`ACT_DATA_W-1:0] a_word;

  always_comb begin
    s_nxt = s_r;
    t_ofs = CFG_ADDR - `ACT_TCAM_BASE;
    a_ofs = CFG_ADDR - `ACT_ANS_BASE;
    t_sel = (CFG_ADDR >= `ACT_TCAM_BASE) && (t_ofs < `ACT_TCAM_SPAN);
    a_sel = (CFG_ADDR >= `ACT_ANS_BASE) && (a_ofs < `ACT_ANS_SPAN);
    t_word = {67'h0, s_r.tcam[t_ofs[7:4]]};
    a_word = {30'h0, s_r.ans[a_ofs[5:2]]};

    // Lowest index wins among simultaneous hits
    tcam_hit = 1'b0;
    hit_idx = '0;
    for (int i = `ACT_ENTRIES - 1; i >= 0; i--) begin
      if (entry_hit[i]) begin
        tcam_hit = 1'b1; // [R24]
        hit_idx = `ACT_IDX_W'(i); // [R24]
      end
    end

    // Hash answer only when present, and over a ternary hit only if chosen
    use_hash = HASH_HIT && (!tcam_hit || s_r.sel_hash); // [R23]
    any_hit = tcam_hit || HASH_HIT;
    if (use_hash) begin
      sel_ans = HASH_ANSWER;
    end else if (tcam_hit) begin
      sel_ans = s_r.ans[hit_idx]; // [R6]
    end else begin
      sel_ans = '0;
    end

    // Hop limit saturates at zero
    ttl_dec = (LOOKUP_TTL == 8'h00) ? 8'h00 : LOOKUP_TTL - 8'h01; // [R9]
    ttl_expired = sel_ans[`ACT_A_HOP_DEC] && (ttl_dec == 8'h00); // [R9]

    // Result registers
    s_nxt.res_valid = LOOKUP_VALID;
    s_nxt.res_stat_update = 1'b0;
    if (LOOKUP_VALID) begin
      s_nxt.res_hit = any_hit; // [R24]
      s_nxt.res_from_hash = use_hash;
      s_nxt.res_index = hit_idx;
      s_nxt.res_ans = sel_ans; // [R7] [R11] [R12] [R13] [R15] [R16] [R17] [R19] [R20] [R21] [R22]
      s_nxt.res_ttl = sel_ans[`ACT_A_HOP_DEC] ? ttl_dec : LOOKUP_TTL; // [R9]
      s_nxt.res_discard = sel_ans[`ACT_A_DISCARD] || (ttl_expired && !s_r.ttl_to_host); // [R10] [R9]
      s_nxt.res_to_host = sel_ans[`ACT_A_TO_HOST] || (ttl_expired && s_r.ttl_to_host); // [R8] [R9]
      s_nxt.res_stat_update = sel_ans[`ACT_A_STAT_EN]; // [R14]
      // Reserved code 3 has no defined type, so no change is requested
      s_nxt.res_tpid_update = sel_ans[`ACT_A_TPID_EN] &&
                              (act_tpid_sel_t'(sel_ans[`ACT_A_TPID_SEL]) != ACT_TPID_RSVD); // [R18]
      unique case (act_tpid_sel_t'(sel_ans[`ACT_A_TPID_SEL]))
        ACT_TPID_C: s_nxt.res_tpid = `ACT_TPID_CUSTOMER; // [R18]
        ACT_TPID_S: s_nxt.res_tpid = `ACT_TPID_SERVICE; // [R18]
        ACT_TPID_USER: s_nxt.res_tpid = s_r.user_tpid; // [R18]
        ACT_TPID_RSVD: s_nxt.res_tpid = `ACT_TPID_CUSTOMER;
      endcase
    end

    // Drop counter: a clear by write never swallows a same-cycle drop
    s_nxt.drops = ((CFG_WR && CFG_ADDR == `ACT_DROPS_ADDR) ? '0 : s_r.drops)
                  + `ACT_DROPS_W'(LOOKUP_VALID && sel_ans[`ACT_A_DISCARD]); // [R10]

    // Configuration writes
    if (CFG_WR) begin
      if (t_sel) begin
        // Bits past the entry width fall off in the slice below
        t_word[t_ofs[3:0]*`ACT_DATA_W +: `ACT_DATA_W] = CFG_WDATA;
        s_nxt.tcam[t_ofs[7:4]] = t_word[`ACT_TCAM_W-1:0]; // [R1]
      end else if (a_sel) begin
        a_word[a_ofs[1:0]*`ACT_DATA_W +: `ACT_DATA_W] = CFG_WDATA;
        s_nxt.ans[a_ofs[5:2]] = a_word[`ACT_ANS_W-1:0]; // [R6]
      end else if (CFG_ADDR == `ACT_CTRL_ADDR) begin
        s_nxt.sel_hash = CFG_WDATA[`ACT_CTRL_SEL]; // [R23]
        s_nxt.ttl_to_host = CFG_WDATA[`ACT_CTRL_TTL_HOST]; // [R9]
      end else if (CFG_ADDR == `ACT_TPID_ADDR) begin
        s_nxt.user_tpid = CFG_WDATA[15:0];
      end
    end

    // Configuration reads, answered next cycle; unmapped reads give zero
    s_nxt.rdata = '0;
    if (CFG_RD) begin
      if (t_sel) begin
        s_nxt.rdata = t_word[t_ofs[3:0]*`ACT_DATA_W +: `ACT_DATA_W];
      end else if (a_sel) begin
        s_nxt.rdata = a_word[a_ofs[1:0]*`ACT_DATA_W +: `ACT_DATA_W];
      end else if (CFG_ADDR == `ACT_CTRL_ADDR) begin
        s_nxt.rdata = {30'h0, s_r.ttl_to_host, s_r.sel_hash};
      end else if (CFG_ADDR == `ACT_TPID_ADDR) begin
        s_nxt.rdata = {16'h0, s_r.user_tpid};
      end else if (CFG_ADDR == `ACT_DROPS_ADDR) begin
        s_nxt.rdata = s_r.drops;
      end else if (CFG_ADDR == `ACT_STATUS_ADDR) begin
        s_nxt.rdata = {25'h0, s_r.res_from_hash, s_r.res_hit, s_r.res_index, s_r.res_valid};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s_r <= reset_state();
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from state

  assign CFG_RDATA = s_r.rdata;
  assign RES_VALID = s_r.res_valid;
  assign RES_HIT = s_r.res_hit;
  assign RES_FROM_HASH = s_r.res_from_hash;
  assign RES_INDEX = s_r.res_index;
  assign RES_ANSWER = s_r.res_ans;
  assign MAC_REWRITE_EN = s_r.res_ans[`ACT_A_MAC_EN];
  assign MAC_ACTION_INDEX = s_r.res_ans[`ACT_A_MAC_IDX];
  assign MAC_REWRITE_PRIORITY = s_r.res_ans[`ACT_A_MAC_PRIO];
  assign TO_HOST_PORT = s_r.res_to_host;
  assign HOP_LIMIT_DECREMENT = s_r.res_ans[`ACT_A_HOP_DEC];
  assign RES_TTL = s_r.res_ttl;
  assign DISCARD_EN = s_r.res_discard;
  assign REDIRECT_EN = s_r.res_ans[`ACT_A_REDIR_EN];
  assign REDIRECT_TARGET = s_r.res_ans[`ACT_A_REDIR_TGT];
  assign INGRESS_COPY_EN = s_r.res_ans[`ACT_A_COPY_EN];
  assign COPY_TARGET_PORT = s_r.res_ans[`ACT_A_COPY_TGT];
  assign COPY_PRIORITY = s_r.res_ans[`ACT_A_COPY_PRIO];
  assign SUPPRESS_SRC_LEARN = s_r.res_ans[`ACT_A_NO_LEARN];
  assign STAT_UPDATE_EN = s_r.res_stat_update;
  assign STAT_INDEX = s_r.res_ans[`ACT_A_STAT_IDX];
  assign DROP_ELIGIBLE_UPDATE_EN = s_r.res_ans[`ACT_A_DEI_EN];
  assign DROP_ELIGIBLE_NEW = s_r.res_ans[`ACT_A_DEI_NEW];
  assign DROP_ELIGIBLE_PRIORITY = s_r.res_ans[`ACT_A_DEI_PRIO];
  assign PRIO_CODE_UPDATE_EN = s_r.res_ans[`ACT_A_PCP_EN];
  assign PRIO_CODE_NEW = s_r.res_ans[`ACT_A_PCP_NEW];
  assign PRIO_CODE_PRIORITY = s_r.res_ans[`ACT_A_PCP_PRIO];
  assign VLAN_ID_UPDATE_EN = s_r.res_ans[`ACT_A_VID_EN];
  assign VLAN_ID_NEW = s_r.res_ans[`ACT_A_VID_NEW];
  assign VLAN_ID_PRIORITY = s_r.res_ans[`ACT_A_VID_PRIO];
  assign TAG_TYPE_UPDATE_EN = s_r.res_tpid_update;
  assign TAG_TYPE_VALUE = s_r.res_tpid;
  assign TAG_TYPE_PRIORITY = s_r.res_ans[`ACT_A_TPID_PRIO];
  assign COLOUR_FORCE_EN = s_r.res_ans[`ACT_A_COL_EN];
  assign COLOUR_VALUE = s_r.res_ans[`ACT_A_COL];
  assign COLOUR_PRIORITY = s_r.res_ans[`ACT_A_COL_PRIO];
  assign POLICER_PTR_VALID = s_r.res_ans[`ACT_A_POL_VALID];
  assign POLICER_PTR = s_r.res_ans[`ACT_A_POL_PTR];
  assign POLICER_PTR_ORDER = s_r.res_ans[`ACT_A_POL_ORDER];
  assign QUEUE_FORCE_EN = s_r.res_ans[`ACT_A_QUEUE_EN];
  assign EGRESS_QUEUE_VALUE = s_r.res_ans[`ACT_A_QUEUE];
  assign QUEUE_PRIORITY = s_r.res_ans[`ACT_A_QUEUE_PRIO];
  assign INGRESS_VLAN_OVERRIDE_EN = s_r.res_ans[`ACT_A_IVID_EN];
  assign INGRESS_VLAN_OVERRIDE = s_r.res_ans[`ACT_A_IVID];
  assign INGRESS_VLAN_OVERRIDE_PRIORITY = s_r.res_ans[`ACT_A_IVID_PRIO];

endmodule : act_tcam_lookup

// ===== tb/act_lookup_properties.sv
`timescale 1ns/1ps
`include "act_consts.svh"

module act_lookup_properties (
  // Clock and reset
  input wire logic MCLK,
  input wire logic RESET,
  input wire logic CE,
  // Requests
  input wire logic CFG_RD,
  input wire logic [`ACT_DATA_W-1:0] CFG_RDATA,
  input wire logic LOOKUP_VALID,
  input wire logic [7:0] LOOKUP_TTL,
  input wire logic [`ACT_ANS_W-1:0] HASH_ANSWER,
  // Results
  input wire logic RES_VALID,
  input wire logic RES_HIT,
  input wire logic RES_FROM_HASH,
  input wire logic [`ACT_IDX_W-1:0] RES_INDEX,
  input wire logic [`ACT_ANS_W-1:0] RES_ANSWER,
  input wire logic STAT_UPDATE_EN,
  input wire logic REDIRECT_EN,
  input wire logic [5:0] REDIRECT_TARGET,
  input wire logic TAG_TYPE_UPDATE_EN,
  input wire logic [15:0] TAG_TYPE_VALUE,
  input wire logic HOP_LIMIT_DECREMENT,
  input wire logic [7:0] RES_TTL,
  input wire logic DISCARD_EN
);
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RESET);
  sequence s_take;
    CE && LOOKUP_VALID;
  endsequence
  sequence s_done;
    RES_VALID;
  endsequence
  chk_res_latency: assert property (s_take |=> s_done)
    else $error("lookup gave no result");
  chk_res_pulse: assert property (CE && !LOOKUP_VALID |=> !RES_VALID)
    else $error("result without lookup");
  chk_rd_idle: assert property (CE && !CFG_RD |=> CFG_RDATA == 32'h0)
    else $error("read data outside read slot");
  chk_no_hit: assert property (RES_VALID && !RES_HIT |-> RES_ANSWER == '0 && RES_INDEX == '0)
    else $error("miss carries answer");
  chk_stat_pulse: assert property (STAT_UPDATE_EN == (RES_VALID && RES_ANSWER[30]))
    else $error("statistics pulse wrong");
  chk_redir_map: assert property (RES_VALID |-> REDIRECT_EN == RES_ANSWER[14] && REDIRECT_TARGET == RES_ANSWER[20:15])
    else $error("redirect decode wrong");
  chk_tag_code: assert property (RES_VALID && RES_ANSWER[58] && RES_ANSWER[60:59] < 2'h2
    |-> TAG_TYPE_UPDATE_EN && TAG_TYPE_VALUE == (RES_ANSWER[59] ? 16'h88A8 : 16'h8100))
    else $error("tag type wrong");
  chk_hash_pick: assert property (s_take ##1 (s_done and RES_FROM_HASH) |-> RES_ANSWER == $past(HASH_ANSWER))
    else $error("hash answer not passed");
  chk_ttl_sat: assert property (s_take ##1 (s_done and HOP_LIMIT_DECREMENT)
    |-> RES_TTL == ($past(LOOKUP_TTL) == 8'h00 ? 8'h00 : $past(LOOKUP_TTL) - 8'h01))
    else $error("hop limit wrong");
  chk_discard: assert property (RES_VALID && RES_ANSWER[13] |-> DISCARD_EN)
    else $error("discard missing");
endmodule : act_lookup_properties

bind act_tcam_lookup act_lookup_properties u_props (.MCLK(MCLK), .RESET(RESET), .CE(CE), .CFG_RD(CFG_RD),
  .CFG_RDATA(CFG_RDATA), .LOOKUP_VALID(LOOKUP_VALID), .LOOKUP_TTL(LOOKUP_TTL), .HASH_ANSWER(HASH_ANSWER),
  .RES_VALID(RES_VALID), .RES_HIT(RES_HIT), .RES_FROM_HASH(RES_FROM_HASH), .RES_INDEX(RES_INDEX),
  .RES_ANSWER(RES_ANSWER), .STAT_UPDATE_EN(STAT_UPDATE_EN), .REDIRECT_EN(REDIRECT_EN),
  .REDIRECT_TARGET(REDIRECT_TARGET), .TAG_TYPE_UPDATE_EN(TAG_TYPE_UPDATE_EN), .TAG_TYPE_VALUE(TAG_TYPE_VALUE),
  .HOP_LIMIT_DECREMENT(HOP_LIMIT_DECREMENT), .RES_TTL(RES_TTL), .DISCARD_EN(DISCARD_EN));

// ===== tb/act_hdr_source.sv
`timescale 1ns/1ps
`include "act_consts.svh"

module act_hdr_source (
  // Clock
  input wire logic clk,
  // Request towards the lookup
  output logic valid,
  output logic [`ACT_KEY_W-1:0] key,
  output logic [7:0] ttl,
  output logic hash_hit,
  output logic [`ACT_ANS_W-1:0] hash_ans
);
  initial begin
    valid = 1'b0;
    key = '0;
    ttl = 8'h00;
    hash_hit = 1'b0;
    hash_ans = '0;
  end
  task send(input logic [`ACT_KEY_W-1:0] k, input logic [7:0] t, input logic h, input logic [`ACT_ANS_W-1:0] a);
    @(posedge clk);
    valid <= 1'b1;
    key <= k;
    ttl <= t;
    hash_hit <= h;
    hash_ans <= a;
  endtask : send
  // Released fields flip so stale values never look valid
  task stop();
    @(posedge clk);
    valid <= 1'b0;
    key <= ~key;
    ttl <= ~ttl;
    hash_hit <= ~hash_hit;
    hash_ans <= ~hash_ans;
  endtask : stop
endmodule : act_hdr_source

// ===== tb/tb.sv
`timescale 1ns/1ps
`include "act_consts.svh"

module tb
  import act_pkg::*;
;
  logic MCLK = 1'b0;
  logic RESET = 1'b1;
  logic CFG_WR = 1'b0;
  logic CFG_RD = 1'b0;
  logic [`ACT_ADDR_W-1:0] CFG_ADDR = '0;
  logic [`ACT_DATA_W-1:0] CFG_WDATA = '0;
  logic [`ACT_DATA_W-1:0] CFG_RDATA;
  logic LOOKUP_VALID, HASH_HIT, RES_VALID, RES_HIT, RES_FROM_HASH, DISCARD_EN, TO_HOST_PORT;
  logic [`ACT_KEY_W-1:0] LOOKUP_KEY;
  logic [7:0] LOOKUP_TTL, RES_TTL;
  logic [`ACT_ANS_W-1:0] HASH_ANSWER, RES_ANSWER;
  logic [3:0] RES_INDEX;
  logic [15:0] TAG_TYPE_VALUE;
  act_tentry_t tc [16];
  act_answer_t an [16];
  logic [1:0] ctl = 2'h0;
  logic [15:0] utp = 16'h8100;
  logic [129:0] lq [$];
  logic [31:0] rq [$];
  int num_errors = 0;
  int samples_checked = 0;
  int ndrop = 0;
  int cyc = 0;
  logic rd_seen = 1'b0;
  logic CE = 1'b1;
  logic [129:0] xr;
  wire [93:0] dec;

  initial begin
    forever #20 MCLK = ~MCLK;
  end

  act_hdr_source src (.clk(MCLK), .valid(LOOKUP_VALID), .key(LOOKUP_KEY), .ttl(LOOKUP_TTL), .hash_hit(HASH_HIT),
    .hash_ans(HASH_ANSWER));
  act_tcam_lookup dut (.MCLK(MCLK), .RESET(RESET), .CE(CE), .CFG_ADDR(CFG_ADDR), .CFG_WDATA(CFG_WDATA),
    .CFG_WR(CFG_WR), .CFG_RD(CFG_RD), .CFG_RDATA(CFG_RDATA), .LOOKUP_VALID(LOOKUP_VALID), .LOOKUP_KEY(LOOKUP_KEY),
    .LOOKUP_TTL(LOOKUP_TTL), .HASH_HIT(HASH_HIT), .HASH_ANSWER(HASH_ANSWER), .RES_VALID(RES_VALID),
    .RES_HIT(RES_HIT), .RES_FROM_HASH(RES_FROM_HASH), .RES_INDEX(RES_INDEX), .RES_ANSWER(RES_ANSWER),
    .MAC_REWRITE_EN(dec[0]), .MAC_ACTION_INDEX(dec[9:1]), .MAC_REWRITE_PRIORITY(dec[10]),
    .TO_HOST_PORT(TO_HOST_PORT), .HOP_LIMIT_DECREMENT(dec[11]), .RES_TTL(RES_TTL), .DISCARD_EN(DISCARD_EN),
    .REDIRECT_EN(dec[12]), .REDIRECT_TARGET(dec[18:13]), .INGRESS_COPY_EN(dec[19]),
    .COPY_TARGET_PORT(dec[25:20]), .COPY_PRIORITY(dec[26]), .SUPPRESS_SRC_LEARN(dec[27]),
    .STAT_UPDATE_EN(dec[28]), .STAT_INDEX(dec[36:29]), .DROP_ELIGIBLE_UPDATE_EN(dec[37]),
    .DROP_ELIGIBLE_NEW(dec[38]), .DROP_ELIGIBLE_PRIORITY(dec[56]), .PRIO_CODE_UPDATE_EN(dec[39]),
    .PRIO_CODE_NEW(dec[42:40]), .PRIO_CODE_PRIORITY(dec[57]), .VLAN_ID_UPDATE_EN(dec[43]),
    .VLAN_ID_NEW(dec[55:44]), .VLAN_ID_PRIORITY(dec[58]), .TAG_TYPE_UPDATE_EN(dec[93]),
    .TAG_TYPE_VALUE(TAG_TYPE_VALUE), .TAG_TYPE_PRIORITY(dec[59]), .COLOUR_FORCE_EN(dec[60]),
    .COLOUR_VALUE(dec[62:61]), .COLOUR_PRIORITY(dec[63]), .POLICER_PTR_VALID(dec[64]), .POLICER_PTR(dec[71:65]),
    .POLICER_PTR_ORDER(dec[73:72]), .QUEUE_FORCE_EN(dec[74]), .EGRESS_QUEUE_VALUE(dec[77:75]),
    .QUEUE_PRIORITY(dec[78]), .INGRESS_VLAN_OVERRIDE_EN(dec[79]), .INGRESS_VLAN_OVERRIDE(dec[91:80]),
    .INGRESS_VLAN_OVERRIDE_PRIORITY(dec[92]));

  ////////////////////////////////////////////////////////////////////////////
  task check(input logic [129:0] seen, input logic [129:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task results();
    $display("errors %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  task wr(input logic [18:0] a, input logic [31:0] d);
    @(posedge MCLK);
    CFG_WR <= 1'b1;
    CFG_ADDR <= a;
    CFG_WDATA <= d;
    @(posedge MCLK);
    CFG_WR <= 1'b0;
    CFG_WDATA <= ~d;
  endtask : wr

  task rd(input logic [18:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge MCLK);
    CFG_RD <= 1'b1;
    CFG_ADDR <= a;
    @(posedge MCLK);
    CFG_RD <= 1'b0;
  endtask : rd

  function automatic logic [447:0] rnd();
    logic [447:0] r;
    for (int i = 0; i < 14; i++) r[32 * i +: 32] = $urandom;
    return r;
  endfunction : rnd

  // Expected result from the table copies held here
  function automatic logic [129:0] model(input logic [221:0] k, input logic [7:0] t, input logic h,
    input act_answer_t ha);
    logic hit;
    logic fh;
    logic [3:0] ix;
    act_answer_t a;
    logic [7:0] nt;
    logic ex;
    logic [15:0] tv;
    hit = 1'b0;
    ix = 4'h0;
    for (int e = 15; e >= 0; e--) begin
      if (tc[e][0] && ((k & tc[e][222:1]) == tc[e][444:223])) begin
        hit = 1'b1;
        ix = e[3:0];
      end
    end
    fh = h && (!hit || ctl[0]);
    a = fh ? ha : (hit ? an[ix] : '0);
    nt = (a[12] && t != 8'h00) ? t - 8'h01 : t;
    ex = a[12] && nt == 8'h00;
    tv = (a[60:59] == 2'h2) ? utp : ((a[60:59] == 2'h1) ? 16'h88A8 : 16'h8100);
    return {hit | fh, fh, ix, a, nt, a[13] | (ex & !ctl[1]), a[11] | (ex & ctl[1]), a[58] ? tv : 16'h0};
  endfunction : model

  task look(input logic [221:0] k, input logic [7:0] t, input logic h, input act_answer_t ha);
    logic [129:0] x;
    x = model(k, t, h, ha);
    lq.push_back(x);
    ndrop += x[39];
    src.send(k, t, h, ha);
  endtask : look

  ////////////////////////////////////////////////////////////////////////////
  always @(negedge MCLK) begin
    if (RES_VALID === 1'b1) begin
      xr = lq.size() > 0 ? lq.pop_front() : 'x;
      check({RES_HIT, RES_FROM_HASH, RES_INDEX, RES_ANSWER, RES_TTL, DISCARD_EN, TO_HOST_PORT,
        RES_ANSWER[58] ? TAG_TYPE_VALUE : 16'h0}, xr);
      check({36'h0, dec}, {36'h0, (xr[84] && xr[86:85] != 2'h3), xr[123:87], xr[83:40], xr[38],
        xr[36:26]});
    end
    if (rd_seen) begin
      check({98'h0, CFG_RDATA}, rq.size() > 0 ? {98'h0, rq.pop_front()} : 'x);
    end
    rd_seen = CFG_RD;
  end

  always @(posedge MCLK) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors++;
      results();
    end
  end

  initial begin
    logic [447:0] m, p;
    logic [221:0] k;
    logic [7:0] t;
    logic [3:0] ix;
    void'($urandom(32'hE9C30F50));
    repeat (2) @(posedge MCLK);
    RESET <= 1'b0;
    rd(`ACT_CTRL_ADDR, 32'h0);
    rd(`ACT_TPID_ADDR, 32'h8100);
    rd(`ACT_DROPS_ADDR, 32'h0);
    rd(19'h00000, 32'h0);
    rd(`ACT_TCAM_BASE, 32'hFFFFFFFE);
    rd(`ACT_TCAM_BASE + 19'h00016, 32'h7FFFFFFF);
    rd(`ACT_ANS_BASE + 19'h0003F, 32'h0);
    // Entry 0 matches all but is invalid; entry 5 matches all keys
    for (int e = 0; e < 16; e++) begin
      m = rnd();
      p = rnd();
      if (e == 0 || e == 5) m = '0;
      tc[e] = {p[221:0] & m[221:0], m[221:0], e == 0 ? 1'b0 : (e == 5 ? 1'b1 : p[447])};
      p = rnd();
      an[e] = p[97:0];
      for (int w = 0; w < 14; w++) wr(`ACT_TCAM_BASE + 19'(16 * e + w), 32'(tc[e] >> (32 * w)));
      for (int w = 0; w < 4; w++) wr(`ACT_ANS_BASE + 19'(4 * e + w), 32'(an[e] >> (32 * w)));
      rd(`ACT_ANS_BASE + 19'(4 * e + 3), {30'h0, an[e][97:96]});
    end
    utp = 16'($urandom);
    wr(`ACT_TPID_ADDR, {16'h0, utp});
    for (int c = 0; c < 4; c++) begin
      // Second half: entry 5 retired so misses occur, drop count restarts
      if (c == 2) begin
        tc[5][0] = 1'b0;
        wr(`ACT_TCAM_BASE + 19'h00050, tc[5][31:0]);
        ndrop = 0;
        wr(`ACT_DROPS_ADDR, 32'h0);
      end
      ctl = 2'(c);
      wr(`ACT_CTRL_ADDR, {30'h0, ctl});
      repeat (40) begin
        m = rnd();
        p = rnd();
        ix = m[447:444];
        k = tc[ix][444:223] | (m[221:0] & ~tc[ix][222:1]);
        t = p[101] ? 8'(p[100:99]) : p[109:102];
        look(k, t, p[0], p[98:1]);
      end
      src.stop();
    end
    repeat (3) @(posedge MCLK);
    rd(`ACT_DROPS_ADDR, 32'(ndrop));
    // Frozen clock enable: the write must not land
    @(posedge MCLK);
    CE <= 1'b0;
    wr(`ACT_CTRL_ADDR, 32'h0);
    @(posedge MCLK);
    CE <= 1'b1;
    rd(`ACT_CTRL_ADDR, {30'h0, ctl});
    repeat (3) @(posedge MCLK);
    results();
  end
endmodule : tb
